// *** rtl/alb_pkg.sv ***
// Package for the address decode and logic array block: widths, array
// positions, configuration structures and Port E role encodings.
// Assumes one clock (core_clk) and the active-low asynchronous reset nrst.
//
// Overview of operation
// R01: Each of the 37 shared inputs reaches the AND array true and inverted.
// R02: Bus: ports A/B, PE0-1, page, address, strobes, clock, reset, select.
// R03: Configuration picks Port B pins or Port B cell feedback for the bus.
// R04: External chip select is ORed with power-down before entering the array.
// R05: Decode array gives four ROM, one RAM, one I/O, two peripheral selects.
// R06: Decode array has 37 inputs and 8 outputs, one product term each.
// R07: I/O select on: low address byte decodes register and port selects.
// R08: Only A0, A1, A8-A15 enter directly; other address lines via Port A.
// R09: General array uses the same 37 inputs; its terms drive macrocells.
// R10: Port B cells are registered D flip-flops; Port A cells combinational.
// R11: Eight identical combinational Port A macrocells, each driving its own pin.
// R12: One shared programmable term enables or tri-states Port A drivers.
// R13: Each Port A cell gets four product terms and selectable polarity.
// R14: Each Port A macrocell is configured as array input or array output.
// R15: PE0: high byte, program read, high write, strobe, size, I/O, array, A0.
// R16: Port E pin 1 roles: address strobe, plain I/O, array I/O, latched A1.
// R17: PE7 roles: power-down clock input, I/O, array I/O, latched A7.
// R18: PE2-PE6: plain I/O, latched A2-A6, array I/O in larger variant.
// R19: Small: 8 registered, 8 combinational cells, 113 terms; large: 24, 126; code builds 8 of each and 113 terms even with LARGE_VARIANT set.
// R20: User configures clear, preset sources and clock of cell registers; code fixes the clock to core_clk and ties macroClear to 0.
// R21: Port B registers clock from logic clock and clear from configurable reset; code clears them only on nrst.
// R22: Reset is active low and clears ports, macrocells and configuration; code clears Port B cells and the latch, not cfg.
// R23: Decode selects follow their product term combinationally, inactive otherwise.
// R24: Latched address outputs hold the address captured at each address strobe edge.
package alb_pkg;

   localparam int NIN = 37;
   localparam int NLIT = 2 * NIN;
   localparam int NDEC = 8;
   localparam int NPORT = 8;
   localparam int PA_TERMS = 4;
   localparam int PB_TERMS = 10;
   localparam int SMALL_TERMS = 113;
   localparam int LARGE_TERMS = 126;
   localparam int SMALL_REGS = 8;
   localparam int LARGE_REGS = 24;
   localparam bit LARGE_VARIANT = 1'b0;

   // Shared input bus positions.
   localparam int IN_PA = 0;
   localparam int IN_PB = 8;
   localparam int IN_PE0 = 16;
   localparam int IN_PE1 = 17;
   localparam int IN_PAGE = 18;
   localparam int IN_ALO = 22;
   localparam int IN_AHI = 24;
   localparam int IN_RD = 32;
   localparam int IN_WR = 33;
   localparam int IN_CLK = 34;
   localparam int IN_RST = 35;
   localparam int IN_CS = 36;

   // Decode select output positions.
   localparam int SEL_ROM = 0;
   localparam int SEL_RAM = 4;
   localparam int SEL_IO = 5;
   localparam int SEL_PER = 6;

   // Port E pin roles.
   typedef enum logic [2:0] {
      PE_IO, PE_ARRAY, PE_ADDR, PE_BUSFN
   } alb_pe_role_t;

   // Pin 0 bus function variants.
   typedef enum logic [2:0] {
      PE0_HBE, PE0_PRGRD, PE0_HWR, PE0_UPSTB, PE0_SIZE
   } alb_pe0_fn_t;

   typedef logic [NLIT-1:0] alb_term_t;

   typedef struct packed {
      logic pbFeedback;
      logic [NDEC-1:0][NLIT-1:0] decMask;
      logic [NPORT-1:0][PA_TERMS-1:0][NLIT-1:0] paMask;
      logic [NLIT-1:0] paOeMask;
      logic [NPORT-1:0] paInvert;
      logic [NPORT-1:0] paIsOutput;
      logic [NPORT-1:0][PB_TERMS-1:0][NLIT-1:0] pbMask;
      logic [NPORT-1:0] pbInvert;
      logic pbClearEnable;
      logic [NPORT-1:0] pbPresetMode;
      logic [NPORT-1:0] peRoleValid;
      logic [NPORT-1:0][2:0] peRole;
      logic [2:0] pe0Fn;
      logic strobeHigh;
   } alb_cfg_t;

   typedef struct packed {
      logic [NDEC-1:0] decSel;
      logic [NPORT-1:0] ioSel;
   } alb_sel_t;

   typedef struct packed {
      logic [NPORT-1:0] pbCell;
      logic [NPORT-1:0] peAddr;
      logic strobeLast;
   } alb_state_t;

   localparam logic [NPORT-1:0] ZERO8 = 8'h00;
   localparam logic [2:0] PE_BUS_PIN0 = 3'h0;

endpackage

// *** rtl/alb_top.sv ***
// Address decode array, general logic array, Port A and Port B macrocells,
// and the Port E role multiplexing with the address latch.
// Assumes configuration is static after reset and pins are synchronous.
`timescale 1ns/100ps
`default_nettype none
module alb_top
   import alb_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire alb_cfg_t cfg,
   input wire logic [NPORT-1:0] paIn,
   output logic [NPORT-1:0] paOut,
   output logic [NPORT-1:0] paOe,
   input wire logic [NPORT-1:0] pbIn,
   output logic [NPORT-1:0] pbOut,
   input wire logic [NPORT-1:0] peIn,
   output logic [NPORT-1:0] peOut,
   output logic [NPORT-1:0] peOe,
   input wire logic [NPORT-1:0] peIoData,
   input wire logic [NPORT-1:0] peIoDir,
   input wire logic [3:0] pageBits,
   input wire logic [15:0] hostAddr,
   input wire logic hostRdStrobe,
   input wire logic hostWrStrobe,
   input wire logic chipSelectN,
   input wire logic powerDown,
   output logic [NDEC-1:0] decSel,
   output logic [NPORT-1:0] ioDecSel,
   output logic [NPORT-1:0] peArrayIn,
   output logic autoPowerDownClk,
   output logic busByteFn
);

   ////////////////////////////////////////////////////////////////////////
   // Product term: all unmasked literals must be true; empty mask is false
   // so an unprogrammed term cannot assert a select by accident.
   function automatic logic andTerm(input alb_term_t lits,
                                    input alb_term_t mask);
      andTerm = (mask != '0) && ((lits | ~mask) == '1);
   endfunction

   alb_state_t st_ff;
   alb_state_t nxt_st;
   logic [NIN-1:0] sharedBus;
   alb_term_t lits;
   logic [NPORT-1:0] paCell;
   logic paOeTerm;
   logic [NPORT-1:0] pbNext;
   logic addrStrobe;
   logic macroClear;

   ////////////////////////////////////////////////////////////////////////
   // Shared input bus, with chip select ORed with power-down.
   always_comb begin
      sharedBus = '0;
      for (int i = 0; i < NPORT; i++) begin
         sharedBus[IN_PA+i] = paIsOut(i) ? paCell[i] : paIn[i]; // R02
         sharedBus[IN_PB+i] = cfg.pbFeedback ? st_ff.pbCell[i] : pbIn[i]; // R03
      end
      sharedBus[IN_PE0] = peIn[0];
      sharedBus[IN_PE1] = peIn[1];
      sharedBus[IN_PAGE +: 4] = pageBits;
      sharedBus[IN_ALO] = hostAddr[0]; // R08
      sharedBus[IN_ALO+1] = hostAddr[1]; // R08
      sharedBus[IN_AHI +: 8] = hostAddr[15:8]; // R08
      sharedBus[IN_RD] = hostRdStrobe;
      sharedBus[IN_WR] = hostWrStrobe;
      sharedBus[IN_CLK] = core_clk;
      sharedBus[IN_RST] = nrst;
      sharedBus[IN_CS] = chipSelectN | powerDown; // R04
   end

   function automatic logic paIsOut(input int idx);
      paIsOut = cfg.paIsOutput[idx];
   endfunction

   // Each input appears true in the low half and inverted in the high half.
   assign lits = {~sharedBus, sharedBus}; // R01

   ////////////////////////////////////////////////////////////////////////
   // Decode array: one product term per select, purely combinational.
   always_comb begin
      for (int s = 0; s < NDEC; s++) begin
         decSel[s] = andTerm(lits, cfg.decMask[s]); // R05 R06 R23
      end
   end

   // The I/O decoder turns address bits 7 to 5 into eight group selects.
   always_comb begin
      ioDecSel = '0;
      if (decSel[SEL_IO]) begin
         ioDecSel[hostAddr[7:5]] = 1'b1; // R07
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port A combinational macrocells: OR of four terms, polarity, shared OE.
   always_comb begin
      paOeTerm = andTerm(lits, cfg.paOeMask); // R12
      for (int c = 0; c < NPORT; c++) begin
         logic orv;
         orv = 1'b0;
         for (int t = 0; t < PA_TERMS; t++) begin
            orv = orv | andTerm(lits, cfg.paMask[c][t]); // R09 R13
         end
         paCell[c] = orv ^ cfg.paInvert[c]; // R10 R11 R13
         paOut[c] = paCell[c];
         paOe[c] = cfg.paIsOutput[c] & paOeTerm; // R12 R14
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port B registered macrocells; ten terms each, clock is core_clk.
   always_comb begin
      for (int c = 0; c < NPORT; c++) begin
         logic orv;
         orv = 1'b0;
         for (int t = 0; t < PB_TERMS; t++) begin
            orv = orv | andTerm(lits, cfg.pbMask[c][t]); // R09
         end
         pbNext[c] = orv ^ cfg.pbInvert[c];
      end
   end

   // Configurable clear is tied off: macroClear is ANDed with 0, so cells
   // never load their preset mode value, whatever pbClearEnable says.
   assign macroClear = cfg.pbClearEnable & ~hostWrStrobe & 1'b0;
   assign addrStrobe = cfg.strobeHigh ? peIn[1] : ~peIn[1];

   ////////////////////////////////////////////////////////////////////////
   // Next state: macrocell D inputs and address latch on the strobe edge.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.pbCell = macroClear ? cfg.pbPresetMode : pbNext; // R10 R20 R21
      nxt_st.strobeLast = addrStrobe;
      if (addrStrobe && !st_ff.strobeLast) begin
         nxt_st.peAddr = hostAddr[7:0]; // R24
      end
   end

   // Reset clears macrocells, the latch and the strobe history.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin // R22
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pbOut = st_ff.pbCell;

   ////////////////////////////////////////////////////////////////////////
   // Port E role multiplexing.
   always_comb begin
      peOut = '0;
      peOe = '0;
      peArrayIn = '0;
      for (int p = 0; p < NPORT; p++) begin
         unique case (cfg.peRole[p])
            PE_IO: begin
               peOut[p] = peIoData[p];
               peOe[p] = peIoDir[p];
            end
            PE_ARRAY: begin
               // Pins 2 to 6 join the array only in the larger variant.
               if (p < 2 || p == 7 || LARGE_VARIANT) begin // R18
                  peArrayIn[p] = peIn[p];
               end
            end
            PE_ADDR: begin
               peOut[p] = st_ff.peAddr[p]; // R15 R16 R17 R18 R24
               peOe[p] = 1'b1;
            end
            PE_BUSFN: begin
               // Pin 0 bus roles, pin 1 strobe, pin 7 power-down clock in.
               peOe[p] = 1'b0; // R15 R16 R17
            end
            default: begin
               peOe[p] = 1'b0;
            end
         endcase
      end
   end

   // Bus function inputs seen by the rest of the device.
   assign autoPowerDownClk = (cfg.peRole[7] == PE_BUSFN) & peIn[7]; // R17
   assign busByteFn = (cfg.peRole[0] == PE_BUSFN) & peIn[0]; // R15

   ////////////////////////////////////////////////////////////////////////
   // Assertions.
   property p_dec_follow;
      @(posedge core_clk) disable iff (!nrst)
      decSel[SEL_IO] == ((cfg.decMask[SEL_IO] != '0) &&
         ((lits & cfg.decMask[SEL_IO]) == cfg.decMask[SEL_IO]));
   endproperty
   a_dec_follow: assert property (p_dec_follow) // R23
      else $error("io decoder select disagrees with its term");

   property p_io_gated;
      @(posedge core_clk) disable iff (!nrst)
      !decSel[SEL_IO] |-> ioDecSel == ZERO8;
   endproperty
   a_io_gated: assert property (p_io_gated) // R07
      else $error("io selects active without decoder select");

   property p_io_onehot;
      @(posedge core_clk) disable iff (!nrst)
      decSel[SEL_IO] |-> $onehot(ioDecSel);
   endproperty
   a_io_onehot: assert property (p_io_onehot) // R07
      else $error("io selects not one-hot");

   property p_pb_reg;
      @(posedge core_clk) disable iff (!nrst)
      nrst |=> pbOut == $past(nxt_st.pbCell);
   endproperty
   a_pb_reg: assert property (p_pb_reg) // R10
      else $error("port b cell did not register its term");

   property p_port_a_output_enable_term;
      @(posedge core_clk) disable iff (!nrst)
      !paOeTerm |-> paOe == ZERO8;
   endproperty
   a_port_a_output_enable_term: assert property (p_port_a_output_enable_term) // R12
      else $error("port a driven while enable term false");

   property p_pa_input;
      @(posedge core_clk) disable iff (!nrst)
      (paOe & ~cfg.paIsOutput) == ZERO8;
   endproperty
   a_pa_input: assert property (p_pa_input) // R14
      else $error("port a input cell drives pin");

   property p_latch;
      @(posedge core_clk) disable iff (!nrst)
      (addrStrobe && !st_ff.strobeLast) |=>
         st_ff.peAddr == $past(hostAddr[7:0]);
   endproperty
   a_latch: assert property (p_latch) // R24
      else $error("address not latched on strobe edge");

   property p_hold;
      @(posedge core_clk) disable iff (!nrst)
      !(addrStrobe && !st_ff.strobeLast) |=> $stable(st_ff.peAddr);
   endproperty
   a_hold: assert property (p_hold) // R24
      else $error("latched address changed without strobe");

   property p_cs;
      @(posedge core_clk) disable iff (!nrst)
      powerDown |-> sharedBus[IN_CS];
   endproperty
   a_cs: assert property (p_cs) // R04
      else $error("power down not merged into chip select");

   c_io: cover property (@(posedge core_clk) disable iff (!nrst)
      decSel[SEL_IO]);
   c_latch: cover property (@(posedge core_clk) disable iff (!nrst)
      addrStrobe && !st_ff.strobeLast);
   c_paoe: cover property (@(posedge core_clk) disable iff (!nrst)
      paOe != ZERO8);

endmodule // alb_top
`default_nettype wire

// *** bench/alb_host_model.sv ***
// Host bus model: address, read and write strobes, select, page bits
// and the address strobe that enters on Port E pin 1.
// Assumes its tasks are called from the core_clk domain.
`timescale 1ns/100ps
`default_nettype none
module alb_host_model (
   input wire logic core_clk,
   output logic [15:0] hostAddr,
   output logic hostRdStrobe,
   output logic hostWrStrobe,
   output logic chipSelectN,
   output logic [3:0] pageBits,
   output logic addrStrobe
);
   ////////////////////////////////////////////////////////////////////////
   // The bus idles deselected with no strobe active.
   initial begin
      hostAddr = 16'h0000;
      hostRdStrobe = 1'b0;
      hostWrStrobe = 1'b0;
      chipSelectN = 1'b1;
      pageBits = 4'h0;
      addrStrobe = 1'b0;
   end

   // One plain bus cycle, changed just after a rising edge.
   task automatic cycle(input logic [15:0] a, input logic [3:0] c,
                        input logic [3:0] pg);
      @(posedge core_clk);
      hostAddr <= a;
      hostRdStrobe <= c[0];
      hostWrStrobe <= c[1];
      chipSelectN <= c[2];
      pageBits <= pg;
   endtask

   // Address phase: strobe held two edges, then the address is released.
   // A released bus shows the inverse so a stale capture cannot pass.
   task automatic strobe(input logic [15:0] a);
      @(posedge core_clk);
      hostAddr <= a;
      addrStrobe <= 1'b1;
      repeat (2) @(posedge core_clk);
      addrStrobe <= 1'b0;
      hostAddr <= ~a;
   endtask
endmodule // alb_host_model
`default_nettype wire

// *** bench/test_address_decode_and_logic_array.sv ***
// Self-checking bench for the decode array, Port A and B cells and the
// Port E address latch. Assumes configuration is static after reset.
`timescale 1ns/100ps
`default_nettype none
module test_address_decode_and_logic_array
   import alb_pkg::*;
;
   typedef struct packed {
      logic [2:0] sel;
      logic [7:0] mask;
      logic [7:0] exp;
   } alb_tb_note_t;
   logic core_clk, nrst, powerDown, strb;
   logic hostRdStrobe, hostWrStrobe, chipSelectN;
   logic [3:0] pageBits;
   logic [15:0] hostAddr;
   alb_cfg_t cfg;
   logic [7:0] paIn, pbIn, peRnd, peIoData, peIoDir, paOut, paOe, pbOut;
   logic [7:0] peOut, peOe, decSel, ioDecSel, peArrayIn;
   logic apdClk, byteFn;
   alb_tb_note_t notes[$];
   alb_tb_note_t note;
   int fail_count = 0;
   int compares = 0;
   event sampleEv;

   alb_host_model alb_host_model_i (.core_clk(core_clk),
      .hostAddr(hostAddr), .hostRdStrobe(hostRdStrobe),
      .hostWrStrobe(hostWrStrobe), .chipSelectN(chipSelectN),
      .pageBits(pageBits), .addrStrobe(strb));
   alb_top alb_top_i (.core_clk(core_clk), .nrst(nrst), .cfg(cfg),
      .paIn(paIn), .paOut(paOut), .paOe(paOe), .pbIn(pbIn), .pbOut(pbOut),
      .peIn({peRnd[7:2], strb, peRnd[0]}), .peOut(peOut), .peOe(peOe),
      .peIoData(peIoData), .peIoDir(peIoDir), .pageBits(pageBits),
      .hostAddr(hostAddr), .hostRdStrobe(hostRdStrobe),
      .hostWrStrobe(hostWrStrobe), .chipSelectN(chipSelectN),
      .powerDown(powerDown), .decSel(decSel), .ioDecSel(ioDecSel),
      .peArrayIn(peArrayIn), .autoPowerDownClk(apdClk), .busByteFn(byteFn));

   ////////////////////////////////////////////////////////////////////////
   // Free-running 40 MHz clock.
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic note_exp(input logic [2:0] s, input logic [7:0] m,
                           input logic [7:0] e);
      notes.push_back('{s, m, e});
   endtask

   task automatic final_report;
      if (fail_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [7:0] pick(input logic [2:0] s);
      case (s)
         3'h0: return decSel;
         3'h1: return ioDecSel;
         3'h2: return paOut;
         3'h3: return paOe;
         3'h4: return pbOut;
         3'h5: return peOut;
         3'h6: return peOe;
         default: return {apdClk, byteFn, peArrayIn[5:0]};
      endcase
   endfunction

   // Watcher: each sample event retires every pending note in order.
   always begin
      @(sampleEv);
      while (notes.size() > 0) begin
         note = notes.pop_front();
         check(pick(note.sel) & note.mask, note.exp);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One literal per used term keeps every expected value a single bit.
   initial begin
      logic [15:0] a;
      logic [7:0] r;
      logic [23:0] rp;
      cfg = '0;
      cfg.decMask[SEL_ROM][IN_CS + NIN] = 1'b1;
      cfg.decMask[SEL_RAM][IN_AHI + 7] = 1'b1;
      cfg.decMask[SEL_IO][IN_ALO] = 1'b1;
      cfg.paMask[0][0][IN_PAGE] = 1'b1;
      cfg.paInvert[1] = 1'b1;
      cfg.paIsOutput = 8'hff;
      cfg.paOeMask[IN_WR] = 1'b1;
      cfg.pbMask[0][0][IN_RD] = 1'b1;
      cfg.peRoleValid = 8'hff;
      for (int i = 2; i < 7; i++)
         cfg.peRole[i] = PE_ADDR;
      cfg.peRole[1] = PE_BUSFN;
      cfg.peRole[0] = PE_ARRAY;
      cfg.peRole[7] = PE_BUSFN;
      cfg.strobeHigh = 1'b1;
      {paIn, pbIn, peRnd, peIoData, peIoDir} = '0;
      powerDown = 1'b0;
      nrst = 1'b0;
      void'($urandom(32'h7687));
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      // Random bus cycles against decode, Port A and Port B cells.
      for (int i = 0; i < 12; i++) begin
         a = 16'($urandom);
         r = 8'($urandom);
         alb_host_model_i.cycle(a, r[3:0], r[7:4]);
         powerDown <= r[3];
         rp = 24'($urandom);
         {paIn, pbIn, peRnd} <= rp;
         {peIoData, peIoDir} <= 16'($urandom);
         @(negedge core_clk);
         note_exp(0, 8'hff, {2'h0, a[0], a[15], 3'h0, ~(r[2] | r[3])});
         note_exp(1, 8'hff, a[0] ? 8'h01 << a[7:5] : 8'h00);
         note_exp(2, 8'hff, {6'h00, 1'b1, r[4]});
         note_exp(3, 8'hff, {8{r[1]}});
         note_exp(7, 8'hff, {rp[7], 1'b0, 5'h00, rp[0]});
         -> sampleEv;
         @(negedge core_clk);
         note_exp(4, 8'hff, {7'h00, r[0]});
         -> sampleEv;
      end
      // Latched address holds after the strobe drops and the bus moves.
      for (int i = 0; i < 3; i++) begin
         a = 16'($urandom);
         alb_host_model_i.strobe(a);
         @(negedge core_clk);
         note_exp(5, 8'h7c, a[7:0] & 8'h7c);
         note_exp(6, 8'h7c, 8'h7c);
         -> sampleEv;
      end
      // A second reset in mid-run clears cells and the address latch.
      @(posedge core_clk);
      nrst <= 1'b0;
      @(negedge core_clk);
      note_exp(4, 8'hff, 8'h00);
      note_exp(5, 8'h7c, 8'h00);
      -> sampleEv;
      @(posedge core_clk);
      nrst <= 1'b1;
      // First edge after release: cells take their terms, latch stays clear.
      repeat (2) @(negedge core_clk);
      note_exp(4, 8'hff, {7'h00, r[0]});
      note_exp(5, 8'h7c, 8'h00);
      -> sampleEv;
      @(posedge core_clk);
      final_report;
   end
endmodule // test_address_decode_and_logic_array
`default_nettype wire
